// >>> mfi_input_decoder.sv
// Multifunction input terminal decoder with AHB-Lite register slave
// Assumes synchronous terminal inputs and a single core clock
//
// Behaviour
// - Code 9 gives a terminal no behaviour at all.
// - Codes 0, 1, 2 are low, mid, high step-speed select bits.
// - Step index from select bits picks one of eight preset frequencies.
// - Step index zero takes target from the frequency-source mode setting.
// - Jog ON drives jog frequency, overriding step index and frequency source.
// - Codes 3, 4, 5 are low, mid, high ramp-time select bits.
// - Ramp index picks one of eight accel/decel pairs; zero is default.
// - Code 6 closed while stopped requests DC injection braking.
// - Code 8 requests line bypass and enables speed search meanwhile.
// - Codes 10 and 11 raise and lower running speed.
// - Code 12 enables three-wire push-button start/stop control.
// - Code 13 ON flags external fault, cuts output, latches trip.
// - Code 14 OFF flags external fault, cuts output, latches trip.
// - Code 15 ON forces PID integral accumulator to zero.
// - Code 16 selects open-loop versus PID, applied only while stopped.
// - Code 17 moves control to local settings, only while stopped.
// - Code 18 freezes the analog frequency reference while asserted.
// - Code 19 suspends acceleration and deceleration while asserted.
// - Codes 21, 22, 23 are low, mid, high sequence select bits.
// - Code 24 switches between automatic sequence and manual mode, only while stopped.
// - Code 25 triggers next sequence step; code 26 holds last step.
// - Codes 27, 28 traverse offsets; codes 29 to 32 interlocks.
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module mfi_input_decoder
   import mfi_pkg::*;
#(
   parameter int NUM_TERM = 3
)(
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                nrst,
   // AHB-Lite slave
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   // Terminals and drive state
   input  wire logic [NUM_TERM-1:0] inputTerm,
   input  wire logic                jogIn,
   input  wire logic                driveStopped,
   input  wire mfi_freq_t           analogRef,
   // Speed and ramp
   output mfi_freq_t                targetFreq_q,
   output logic [15:0]              accelTime_q,
   output logic [15:0]              decelTime_q,
   output logic                     rampSuspend_q,
   output logic                     upDrive_q,
   output logic                     downDrive_q,
   output logic                     threeWireEn_q,
   // Braking, bypass, faults
   output logic                     dcInjectReq_q,
   output logic                     bypassReq_q,
   output logic                     speedSearchEn_q,
   output logic                     extFault_q,
   output logic                     outputEnable_q,
   // Control mode
   output logic                     integratorClear_q,
   output logic                     openLoop_q,
   output logic                     localCtrl_q,
   // Sequence, traverse, interlock
   output logic [2:0]               seqSel_q,
   output logic                     autoMode_q,
   output logic                     goStep_q,
   output logic                     holdStep_q,
   output logic                     traverseNegOffset_q,
   output logic                     traversePosOffset_q,
   output logic [3:0]               motorInterlock_q
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [31:0]     codes_q;
   mfi_src_t        freqSourceMode_q;
   mfi_src_t        activeSrc_q;
   mfi_freq_t       jogFreq_q;
   mfi_freq_t       stepFreq_q [8];
   logic [31:0]     rampPair_q [8];
   mfi_freq_t       analogHeld_q;
   logic            goStepPrev_q;
   logic            wrPend_q;
   logic [4:0]      wrIdx_q;
   logic [31:0]     rdData;
   logic            addrPhase;
   logic [4:0]      aIdx;
   mfi_role_t       termRole [NUM_TERM];
   mfi_role_t       role;
   logic [2:0]      stepIdx;
   logic [2:0]      rampIdx;
   logic            tripNow;
   logic            tripClear;

   // Word index of an address, all-ones when outside the map
   function automatic logic [4:0] wordIdx(input logic [31:0] a);
      if (a[31:7] != '0 || a[6:2] > 5'h17) begin
         return 5'h1F;
      end
      return a[6:2];
   endfunction : wordIdx

   ////////////////////////////////////////////////////////////////////////
   // Terminal role decoding
   genvar t;
   generate
      for (t = 0; t < NUM_TERM; t++) begin : g_term
         mfi_term_decode u_dec (
            .code    (codes_q[t*`MFI_CODE_PITCH +: `MFI_CODE_W]),
            .level   (inputTerm[t]),
            .roleVec (termRole[t])
         );
      end
   endgenerate

   // Merge roles; unassigned roles stay zero
   always_comb begin
      role = '0;
      for (int i = 0; i < NUM_TERM; i++) begin
         role = role | termRole[i];
      end
   end

   assign stepIdx   = {role[MFI_SPEED_HI], role[MFI_SPEED_MID], role[MFI_SPEED_LO]};
   assign rampIdx   = {role[MFI_RAMP_HI], role[MFI_RAMP_MID], role[MFI_RAMP_LO]};
   assign tripNow   = role[MFI_TRIP_NO] | role[MFI_TRIP_NC];
   assign addrPhase = hsel & htrans[1] & hready;
   assign aIdx      = wordIdx(haddr);
   assign tripClear = wrPend_q & (wrIdx_q == `MFI_IDX_CTRL) & hwdata[`MFI_CTRL_CLR_BIT];

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture, zero wait states
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wrPend_q  <= 1'b0;
         wrIdx_q   <= 5'h1F;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wrPend_q  <= addrPhase & hwrite;
         wrIdx_q   <= aIdx;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addrPhase && !hwrite) begin
            hrdata <= rdData;
         end
      end
   end

   // Read mux, unmapped words read zero
   always_comb begin
      rdData = 32'h0000_0000;
      if (aIdx == `MFI_IDX_CODES) begin
         rdData = codes_q;
      end else if (aIdx == `MFI_IDX_CTRL) begin
         rdData = {30'h0000_0000, freqSourceMode_q};
      end else if (aIdx == `MFI_IDX_JOG) begin
         rdData = {16'h0000, jogFreq_q};
      end else if (aIdx == `MFI_IDX_STATUS) begin
         rdData = {12'h000, extFault_q, openLoop_q, localCtrl_q, autoMode_q,
                   seqSel_q, rampIdx, stepIdx, jogIn, driveStopped,
                   {(5 - NUM_TERM){1'b0}}, inputTerm};
      end else if (aIdx >= `MFI_IDX_STEP_BASE && aIdx < `MFI_IDX_RAMP_BASE) begin
         rdData = {16'h0000, stepFreq_q[aIdx[2:0]]};
      end else if (aIdx >= `MFI_IDX_RAMP_BASE && aIdx != 5'h1F) begin
         rdData = rampPair_q[aIdx[2:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes in the data phase
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         codes_q          <= `MFI_CODES_RST;
         freqSourceMode_q <= MFI_SRC_PRESET;
         jogFreq_q        <= `MFI_JOG_RST;
         for (int i = 0; i < 8; i++) begin
            stepFreq_q[i] <= `MFI_STEP_RST;
            rampPair_q[i] <= `MFI_RAMP_RST;
         end
      end else if (wrPend_q) begin
         if (wrIdx_q == `MFI_IDX_CODES) begin
            codes_q <= hwdata & 32'h003F_3F3F;
         end else if (wrIdx_q == `MFI_IDX_CTRL) begin
            freqSourceMode_q <= mfi_src_t'(hwdata[`MFI_CTRL_SRC_LSB +: 2]);
         end else if (wrIdx_q == `MFI_IDX_JOG) begin
            jogFreq_q <= hwdata[15:0];
         end else if (wrIdx_q >= `MFI_IDX_STEP_BASE && wrIdx_q < `MFI_IDX_RAMP_BASE) begin
            stepFreq_q[wrIdx_q[2:0]] <= hwdata[15:0];
         end else if (wrIdx_q >= `MFI_IDX_RAMP_BASE && wrIdx_q != 5'h1F) begin
            rampPair_q[wrIdx_q[2:0]] <= hwdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Analog reference freeze
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         analogHeld_q <= 16'h0000;
      end else if (!role[MFI_AN_HOLD]) begin
         analogHeld_q <= analogRef;
      end
   end

   // Target frequency selection
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         targetFreq_q <= 16'h0000;
      end else if (jogIn) begin
         targetFreq_q <= jogFreq_q;
      end else if (stepIdx != 3'h0) begin
         targetFreq_q <= stepFreq_q[stepIdx];
      end else if (activeSrc_q == MFI_SRC_ANALOG) begin
         targetFreq_q <= analogHeld_q;
      end else begin
         targetFreq_q <= stepFreq_q[0];
      end
   end

   // Ramp pair selection and suspend
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         accelTime_q   <= 16'h0000;
         decelTime_q   <= 16'h0000;
         rampSuspend_q <= 1'b0;
      end else begin
         accelTime_q   <= rampPair_q[rampIdx][`MFI_RAMP_ACC_LSB +: 16];
         decelTime_q   <= rampPair_q[rampIdx][`MFI_RAMP_DEC_LSB +: 16];
         rampSuspend_q <= role[MFI_RAMP_SUSP];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Drive commands following terminal levels
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dcInjectReq_q     <= 1'b0;
         bypassReq_q       <= 1'b0;
         speedSearchEn_q   <= 1'b0;
         upDrive_q         <= 1'b0;
         downDrive_q       <= 1'b0;
         threeWireEn_q     <= 1'b0;
         integratorClear_q <= 1'b0;
      end else begin
         dcInjectReq_q     <= role[MFI_DC_INJ] & driveStopped;
         bypassReq_q       <= role[MFI_BYPASS];
         speedSearchEn_q   <= role[MFI_BYPASS];
         upDrive_q         <= role[MFI_UP];
         downDrive_q       <= role[MFI_DOWN];
         threeWireEn_q     <= role[MFI_THREE_W];
         integratorClear_q <= role[MFI_ICLEAR];
      end
   end

   // External trip latch, a new trip wins over a clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         extFault_q     <= 1'b0;
         outputEnable_q <= 1'b1;
      end else if (tripNow) begin
         extFault_q     <= 1'b1;
         outputEnable_q <= 1'b0;
      end else if (tripClear) begin
         extFault_q     <= 1'b0;
         outputEnable_q <= 1'b1;
      end
   end

   // Mode switches accepted only while stopped
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         openLoop_q  <= 1'b0;
         localCtrl_q <= 1'b0;
         autoMode_q  <= 1'b1;
         activeSrc_q <= MFI_SRC_PRESET;
      end else if (driveStopped) begin
         openLoop_q  <= role[MFI_OPEN_LOOP];
         localCtrl_q <= role[MFI_LOCAL];
         autoMode_q  <= ~role[MFI_MANUAL];
         activeSrc_q <= freqSourceMode_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequence, traverse and interlock outputs
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         seqSel_q            <= 3'h0;
         goStepPrev_q        <= 1'b0;
         goStep_q            <= 1'b0;
         holdStep_q          <= 1'b0;
         traverseNegOffset_q <= 1'b0;
         traversePosOffset_q <= 1'b0;
         motorInterlock_q    <= 4'h0;
      end else begin
         seqSel_q            <= {role[MFI_SEQ_HI], role[MFI_SEQ_MID], role[MFI_SEQ_LO]};
         goStepPrev_q        <= role[MFI_GO_STEP];
         goStep_q            <= role[MFI_GO_STEP] & ~goStepPrev_q;
         holdStep_q          <= role[MFI_HOLD_STEP];
         traverseNegOffset_q <= role[MFI_TRV_NEG];
         traversePosOffset_q <= role[MFI_TRV_POS];
         motorInterlock_q    <= role[MFI_ILOCK4:MFI_ILOCK1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   property p_trip_latch;
      tripNow |=> extFault_q && !outputEnable_q ##1 (extFault_q || $past(tripClear));
   endproperty
   a_trip_latch: assert property (p_trip_latch) else $error("trip not latched");

   property p_jog_target;
      jogIn |=> targetFreq_q == $past(jogFreq_q);
   endproperty
   a_jog_target: assert property (p_jog_target) else $error("jog not taken");

   property p_step_target;
      !jogIn && stepIdx != 3'h0 |=> targetFreq_q == $past(stepFreq_q[stepIdx]);
   endproperty
   a_step_target: assert property (p_step_target) else $error("step freq wrong");

   property p_dc_inject_req;
      dcInjectReq_q |-> $past(driveStopped) && $past(role[MFI_DC_INJ]);
   endproperty
   a_dc_inject_req: assert property (p_dc_inject_req) else $error("dc_inject_req while running");

   property p_open_loop_hold;
      !driveStopped |=> $stable(openLoop_q) && $stable(localCtrl_q);
   endproperty
   a_open_loop_hold: assert property (p_open_loop_hold) else $error("mode moved running");

   property p_go_pulse;
      goStep_q |=> !goStep_q;
   endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("go step not a pulse");

   property p_ramp_pick;
      nrst |=> accelTime_q == $past(rampPair_q[rampIdx][15:0]);
   endproperty
   a_ramp_pick: assert property (p_ramp_pick) else $error("ramp pair wrong");

   property p_iclear;
      role[MFI_ICLEAR] [*2] |-> ##1 integratorClear_q;
   endproperty
   a_iclear: assert property (p_iclear) else $error("integrator not cleared");

   property p_hold;
      role[MFI_AN_HOLD] |=> $stable(analogHeld_q);
   endproperty
   a_hold: assert property (p_hold) else $error("analog hold moved");

   property p_bus_okay;
      hreadyout && !hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus not ready okay");

endmodule : mfi_input_decoder
`default_nettype wire

// >>> mfi_cfg.svh
// Register map, field positions and reset values of the input decoder
// Assumes 32-bit AHB-Lite words, one register per aligned word
`ifndef MFI_CFG_SVH
`define MFI_CFG_SVH

// Register word indices (byte address = index * 4)
`define MFI_IDX_CODES     5'h00
`define MFI_IDX_CTRL      5'h01
`define MFI_IDX_JOG       5'h02
`define MFI_IDX_STATUS    5'h03
`define MFI_IDX_STEP_BASE 5'h08
`define MFI_IDX_RAMP_BASE 5'h10
`define MFI_ADDR_TOP_W    25

// Code register fields (one 6-bit code per terminal, 8 bits apart)
`define MFI_CODE_W        6
`define MFI_CODE_PITCH    8
`define MFI_CODES_RST     32'h0002_0100

// Control register fields
`define MFI_CTRL_SRC_LSB  0
`define MFI_CTRL_CLR_BIT  8

// Ramp pair fields
`define MFI_RAMP_ACC_LSB  0
`define MFI_RAMP_DEC_LSB  16

// Reset values
`define MFI_JOG_RST       16'h03E8
`define MFI_STEP_RST      16'h0000
`define MFI_RAMP_RST      32'h0064_0064

// Role vector width (codes 0 to 32)
`define MFI_ROLE_W        33

`endif

// >>> mfi_pkg.sv
// Types shared by the input decoder modules
// Assumes mfi_cfg.svh for widths
`include "mfi_cfg.svh"

package mfi_pkg;

   // Terminal function codes
   typedef enum logic [5:0] {
      MFI_SPEED_LO  = 6'h00, MFI_SPEED_MID = 6'h01, MFI_SPEED_HI  = 6'h02,
      MFI_RAMP_LO   = 6'h03, MFI_RAMP_MID  = 6'h04, MFI_RAMP_HI   = 6'h05,
      MFI_DC_INJ    = 6'h06, MFI_SECOND    = 6'h07, MFI_BYPASS    = 6'h08,
      MFI_RESERVED  = 6'h09, MFI_UP        = 6'h0A, MFI_DOWN      = 6'h0B,
      MFI_THREE_W   = 6'h0C, MFI_TRIP_NO   = 6'h0D, MFI_TRIP_NC   = 6'h0E,
      MFI_ICLEAR    = 6'h0F, MFI_OPEN_LOOP = 6'h10, MFI_LOCAL     = 6'h11,
      MFI_AN_HOLD   = 6'h12, MFI_RAMP_SUSP = 6'h13, MFI_PGAIN2    = 6'h14,
      MFI_SEQ_LO    = 6'h15, MFI_SEQ_MID   = 6'h16, MFI_SEQ_HI    = 6'h17,
      MFI_MANUAL    = 6'h18, MFI_GO_STEP   = 6'h19, MFI_HOLD_STEP = 6'h1A,
      MFI_TRV_NEG   = 6'h1B, MFI_TRV_POS   = 6'h1C, MFI_ILOCK1    = 6'h1D,
      MFI_ILOCK4    = 6'h20
   } mfi_func_t;

   // Frequency source selection
   typedef enum logic [1:0] {
      MFI_SRC_PRESET = 2'b00,
      MFI_SRC_ANALOG = 2'b01
   } mfi_src_t;

   typedef logic [15:0]              mfi_freq_t;
   typedef logic [`MFI_ROLE_W-1:0]   mfi_role_t;

endpackage : mfi_pkg

// >>> mfi_term_decode.sv
// Maps one terminal level and its function code onto the role vector
// Assumes level is already synchronous to the core clock
`timescale 1ns/1ps
`default_nettype none

module mfi_term_decode
   import mfi_pkg::*;
(
   // Terminal
   input  wire logic [`MFI_CODE_W-1:0] code,
   input  wire logic                   level,
   // Role
   output logic      [`MFI_ROLE_W-1:0] roleVec
);

   ////////////////////////////////////////////////////////////////////////
   // One-hot role, polarity per code
   always_comb begin
      roleVec = '0;
      if (code == MFI_TRIP_NC) begin
         roleVec[code] = ~level;
      end else if (code != MFI_RESERVED && code <= MFI_ILOCK4) begin
         roleVec[code] = level;
      end
   end

endmodule : mfi_term_decode
`default_nettype wire

// >>> mfi_contacts.sv
// Contact model for the three input terminals
// Assumes the bench sets closeCmd just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none

module mfi_contacts (
   // Clock
   input  wire logic       core_clk,
   // Wanted contact states, 1 = closed
   input  wire logic [2:0] closeCmd,
   // Terminal levels seen by the drive
   output logic      [2:0] inputTerm
);
   // Contacts settle one clock after the command
   always_ff @(posedge core_clk) begin
      inputTerm <= closeCmd;
   end
endmodule : mfi_contacts

`default_nettype wire

// >>> mfi_input_decoder_tb.sv
// Self-checking bench for the input decoder
// Assumes the design answers every bus phase with hreadyout high
`timescale 1ns/1ps
`default_nettype none

module mfi_input_decoder_tb
   import mfi_pkg::*;
;
   logic        core_clk = 0, nrst = 0, hsel = 0, hwrite = 0;
   logic        jogIn = 0, driveStopped = 1, hready;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2, cmd = 0, term, seqSel;
   logic [3:0]  ilk;
   logic [15:0] acc, dec;
   mfi_freq_t   analogRef = 0, tgt;
   logic        hro, hrs, ramp, up, dn, tw, dci, byp, ss, flt, oe;
   logic        icl, opl, loc, aut, go, hld, tn, tp;
   logic [10:0] flg;
   logic [5:0]  tab [11] = '{6'h0A, 6'h0B, 6'h0C, 6'h0F, 6'h13, 6'h1B,
                             6'h1C, 6'h20, 6'h1F, 6'h1E, 6'h1D};
   int          n_errors = 0, checked = 0, n;

   assign hready = hro;
   assign flg = {up, dn, tw, icl, ramp, tn, tp, ilk};

   // Clock
   always #12.5 core_clk = ~core_clk;

   mfi_contacts i_mfi_contacts (.core_clk(core_clk), .closeCmd(cmd), .inputTerm(term));

   mfi_input_decoder i_mfi_input_decoder (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hro), .hresp(hrs), .inputTerm(term),
      .jogIn(jogIn), .driveStopped(driveStopped), .analogRef(analogRef),
      .targetFreq_q(tgt), .accelTime_q(acc), .decelTime_q(dec), .rampSuspend_q(ramp),
      .upDrive_q(up), .downDrive_q(dn), .threeWireEn_q(tw), .dcInjectReq_q(dci),
      .bypassReq_q(byp), .speedSearchEn_q(ss), .extFault_q(flt), .outputEnable_q(oe),
      .integratorClear_q(icl), .openLoop_q(opl), .localCtrl_q(loc), .seqSel_q(seqSel),
      .autoMode_q(aut), .goStep_q(go), .holdStep_q(hld), .traverseNegOffset_q(tn),
      .traversePosOffset_q(tp), .motorInterlock_q(ilk));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare and report
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task end_sim;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // Bus write, address phase then data phase
   task wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge core_clk);
      hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= 1;
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel <= 0; htrans <= 2'h0; hwdata <= v;
      do @(posedge core_clk); while (hready !== 1'b1);
   endtask : wr

   // Bus read, data taken at the end of the data phase
   task rc(input string nm, input logic [31:0] a, input logic [31:0] e);
      @(posedge core_clk);
      hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= 0;
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel <= 0; htrans <= 2'h0;
      do @(posedge core_clk); while (hready !== 1'b1);
      chk(nm, hrdata, e);
   endtask : rc

   // Function codes of terminals a, b, c
   task codes(input logic [5:0] a, input logic [5:0] b, input logic [5:0] c);
      wr(32'h00, {10'h0, c, 2'h0, b, 2'h0, a});
   endtask : codes

   // Contacts, then wait for the decode to land
   task tm(input logic [2:0] v);
      cmd <= v;
      repeat (3) @(posedge core_clk);
   endtask : tm

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      end_sim();
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1;
      chk("oe", oe, 1);
      rc("codes", 32'h00, 32'h0002_0100);
      rc("jog", 32'h08, 32'h03E8);
      rc("ramp0", 32'h40, 32'h0064_0064);
      wr(32'h7C, 32'hFFFF_FFFF);
      rc("unmapped", 32'h7C, 0);
      chk("resp", {hro, hrs}, 2'h2);
      for (int i = 0; i < 8; i++) wr(32'h20 + 4 * i, 32'h0A00 + i);
      for (int i = 0; i < 8; i++) wr(32'h40 + 4 * i, {16'h0200 + i[15:0], 16'h0100 + i[15:0]});
      for (int i = 0; i < 8; i++) begin
         tm(i[2:0]);
         chk("target", tgt, 32'h0A00 + i);
      end
      rc("status", 32'h0C, 32'h0001_03A7);
      jogIn <= 1;
      tm(3'h5);
      chk("jog", tgt, 32'h03E8);
      jogIn <= 0;
      $display("test speed done");
      codes(3, 4, 5);
      for (int i = 0; i < 8; i++) begin
         tm(i[2:0]);
         chk("accel", acc, 32'h0100 + i);
         chk("decel", dec, 32'h0200 + i);
         chk("speed", tgt, 32'h0A00);
      end
      codes(9, 9, 9);
      tm(3'h7);
      chk("reserved", {flg, dci, byp, flt, opl, loc, seqSel, aut}, 32'h1);
      chk("ramp", acc, 32'h0100);
      $display("test ramp done");
      codes(6, 8, 2);
      tm(3'h1);
      chk("dc", dci, 1);
      driveStopped <= 0;
      tm(3'h3);
      chk("dcRun", dci, 0);
      chk("bypass", {byp, ss}, 2'h3);
      driveStopped <= 1;
      for (int k = 0; k < 11; k++) begin
         codes(tab[k], 1, 2);
         tm(3'h1);
         chk("flag", flg, 11'h400 >> k);
         tm(3'h0);
      end
      $display("test level roles done");
      tm(3'h2);
      codes(13, 14, 2);
      wr(32'h04, 32'h100);
      chk("noTrip", {flt, oe}, 2'h1);
      tm(3'h3);
      chk("tripA", {flt, oe}, 2'h2);
      tm(3'h2);
      chk("latchA", {flt, oe}, 2'h2);
      wr(32'h04, 32'h100);
      @(posedge core_clk);
      chk("clear", {flt, oe}, 2'h1);
      tm(3'h0);
      chk("tripB", {flt, oe}, 2'h2);
      rc("ctrl", 32'h04, 0);
      tm(3'h2);
      wr(32'h04, 32'h100);
      $display("test trip done");
      codes(16, 17, 24);
      driveStopped <= 0;
      tm(3'h7);
      chk("modeRun", {opl, loc, aut}, 3'h1);
      driveStopped <= 1;
      tm(3'h7);
      chk("modeStop", {opl, loc, aut}, 3'h6);
      tm(3'h0);
      codes(21, 22, 23);
      tm(3'h5);
      chk("seq", seqSel, 3'h5);
      codes(25, 26, 2);
      tm(3'h2);
      chk("hold", hld, 1);
      cmd <= 3'h3;
      n = 0;
      repeat (6) begin
         @(posedge core_clk);
         n += go;
      end
      chk("goPulses", n, 1);
      $display("test sequence done");
      analogRef <= 16'h1234;
      codes(18, 1, 2);
      wr(32'h04, 32'h1);
      tm(3'h0);
      chk("analog", tgt, 32'h1234);
      tm(3'h1);
      analogRef <= 16'h5678;
      tm(3'h1);
      chk("frozen", tgt, 32'h1234);
      tm(3'h0);
      @(posedge core_clk);
      chk("thawed", tgt, 32'h5678);
      $display("test analog done");
      end_sim();
   end
endmodule : mfi_input_decoder_tb

`default_nettype wire
